// >>> bench/adclim_asserts.sv
// assertion checker for the adc limit and settings bank
`timescale 1ns/1ps
module adclim_chk (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic rd,
    input wire logic conv_start,
    input wire logic conv_accept,
    input wire logic powered_down,
    input wire adclim_pkg::adclim_req_t req,
    input wire adclim_pkg::adclim_ctl_t ctl,
    input wire logic [15:0] rdata,
    input wire logic [13:0] rate_tenths_hz
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    property p_sd; req.wr && req.index == 2'h2 && req.wdata[8]
        |=> ctl.shutdown_pulse ##1 !ctl.shutdown_pulse; endproperty
    a_sd: assert property (p_sd) else $error("bad shutdown pulse");
    property p_pd; ctl.shutdown_pulse && !conv_start |=> powered_down; endproperty
    a_pd: assert property (p_pd) else $error("no power down");
    property p_cs; conv_start |=> !powered_down; endproperty
    a_cs: assert property (p_cs) else $error("no wake");
    property p_ca; conv_accept == conv_start; endproperty
    a_ca: assert property (p_ca) else $error("start refused");
    property p_r0; !ctl.rate_table_select && ctl.rate_code == 3'h0 |=> rate_tenths_hz == 14'h003e; endproperty
    a_r0: assert property (p_r0) else $error("bad rate");
    property p_r1; ctl.rate_table_select && ctl.rate_code == 3'h1 |=> rate_tenths_hz == 14'h0096; endproperty
    a_r1: assert property (p_r1) else $error("bad rate");
    property p_r7; !ctl.rate_table_select && ctl.rate_code == 3'h7 |=> rate_tenths_hz == 14'h1f40; endproperty
    a_r7: assert property (p_r7) else $error("bad top rate");
    property p_t7; ctl.rate_table_select && ctl.rate_code == 3'h7 |=> rate_tenths_hz == 14'h2580; endproperty
    a_t7: assert property (p_t7) else $error("bad top rate");
    property p_ax; req.wr && req.index == 2'h2 |=> ctl.open_input_probe_current == $past(req.wdata[6])
        && ctl.bus_leak_block == $past(req.wdata[4])
        && ctl.outside_reference_select == $past(req.wdata[3]); endproperty
    a_ax: assert property (p_ax) else $error("aux field lost");
    property p_rs; rd && req.index == 2'h2 |=> (rdata & 16'hfe27) == 16'h0000; endproperty
    a_rs: assert property (p_rs) else $error("unused bit set");
    c_sd: cover property (ctl.shutdown_pulse);
    c_pd: cover property ($fell(powered_down));
    c_ws: cover property (ctl.window_style);
endmodule

// >>> bench/adclim_src.sv
// stand-in for the converter core feeding results
`timescale 1ns/1ps
module adclim_src (
    input wire logic sys_clk,
    output logic [23:0] result,
    output logic result_valid
);
    initial begin
        result = 24'h000000;
        result_valid = 1'b0;
    end
    // stale word is inverted so it never passes for a fresh one
    task automatic send(input logic [23:0] v);
        @(posedge sys_clk);
        #1 {result, result_valid} = {v, 1'b1};
        @(posedge sys_clk);
        #1 {result, result_valid} = {~v, 1'b0};
    endtask
endmodule

// >>> bench/tb.sv
// self-checking bench for the adc limit and settings bank
`timescale 1ns/1ps
module tb;
    logic sys_clk = 1'b0, rst_b = 1'b0, rd = 1'b0, conv_start = 1'b0, result_valid, conv_accept, powered_down, alert;
    logic [15:0] rdata;
    logic [15:0] rv [4] = '{16'h8000, 16'h7fff, 16'h0000, 16'h0080};
    logic [13:0] rate_tenths_hz;
    // rate table in tenths of hertz, truncated, table zero then table one
    logic [13:0] rt [16] = '{14'h003e, 14'h007d, 14'h00fa, 14'h01f4, 14'h03e8, 14'h07d0, 14'h0fa0, 14'h1f40,
        14'h004b, 14'h0096, 14'h012c, 14'h0258, 14'h04b0, 14'h0960, 14'h12c0, 14'h2580};
    logic [23:0] result;
    logic [23:0] smp [6] = '{24'h001100, 24'h000000, 24'hfff000, 24'hfff000, 24'hffef00, 24'h000000};
    adclim_pkg::adclim_req_t req = '0;
    adclim_pkg::adclim_ctl_t ctl;
    int mismatches = 0, tests_run = 0, cyc = 0;
    always #5 sys_clk = ~sys_clk;
    adclim_bank u_adclim_bank (.sys_clk, .rst_b, .req, .rd, .rdata, .conv_start, .result_valid, .result,
        .conv_accept, .powered_down, .ctl, .rate_tenths_hz, .alert);
    adclim_src u_src (.sys_clk, .result, .result_valid);
    task automatic print_verdict();
        if (mismatches == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        mismatches += int'(got !== exp);
        if (got !== exp) $display("CHECK FAILED %0t %h %h", $time, got, exp);
    endtask
    task automatic acc(input logic [1:0] i, input logic [15:0] d, input logic w);
        @(posedge sys_clk);
        #1 {req, rd} = {i, d, w, !w};
        @(posedge sys_clk);
        #1 {req.wr, rd} = 2'b00;
        if (!w) chk(rdata, d);
    endtask
    // a hang costs a mismatch, then the normal verdict path
    always @(posedge sys_clk) begin
        cyc = cyc + 1;
        if (cyc == 3000) begin
            mismatches = mismatches + 1;
            print_verdict();
        end
    end
    initial begin
        repeat (3) @(posedge sys_clk);
        #1 rst_b = 1'b1;
        for (int k = 0; k < 4; k++) acc(2'(k), rv[k], 1'b0);
        acc(2'h2, 16'hffff, 1'b1);
        acc(2'h2, 16'h00d8, 1'b0);
        chk({15'h0, powered_down}, 16'h0001);
        conv_start = 1'b1;
        #5 chk({15'h0, conv_accept}, 16'h0001);
        #5 conv_start = 1'b0;
        chk({15'h0, powered_down}, 16'h0000);
        for (int n = 0; n < 16; n++) begin
            acc(2'h2, {8'h0, n > 7, 7'h0}, 1'b1);
            acc(2'h3, 16'((n % 8) << 5), 1'b1);
            @(posedge sys_clk);
            #1 chk({2'h0, rate_tenths_hz}, {2'h0, rt[n]});
        end
        acc(2'h0, 16'hfff0, 1'b1);
        acc(2'h1, 16'h0010, 1'b1);
        for (int i = 0; i < 6; i++) begin
            acc(2'h3, {11'h0, i > 2, 4'h0}, 1'b1);
            u_src.send(smp[i]);
            chk({15'h0, alert}, 16'(i < 2 || i == 4));
        end
        print_verdict();
    end
endmodule
bind adclim_bank adclim_chk u_chk (.sys_clk, .rst_b, .rd, .conv_start, .conv_accept, .powered_down, .req, .ctl,
    .rdata, .rate_tenths_hz);

// >>> src/adclim_bank.sv
// limit registers, auxiliary settings and digital comparator of the adc
// Operation
// RULE_01: limits are 16-bit signed, compared against result bits 23 to 8.
// RULE_02: reset loads lower limit 8000h and upper limit 7fffh.
// RULE_03: writing one to shutdown bit 8 powers down; bit self-clears.
// RULE_04: a new conversion is accepted without clearing the shutdown bit.
// RULE_05: table select zero maps rate codes to 6.25 through 800 Hz.
// RULE_06: table select one maps rate codes to 7.5 through 960 Hz.
// RULE_07: probe bit 6 enables a pair of 2 uA sources.
// RULE_08: leak block bit 4 enables the leakage blocking circuit.
// RULE_09: reference bit 3 selects analog input three as reference.
// RULE_10: all auxiliary fields including reserved bit 5 reset to zero.
// RULE_11: rate code sits at main register bits 7 to 5, reset 100.
// RULE_12: compare style zero is hysteresis, one is window comparison.
// RULE_13: auxiliary bits 15 to 9 and 2 to 0 read zero, ignore writes.
// RULE_14: limit registers update whole, never partly written.
`timescale 1ns/1ps
`include "adclim_regs.svh"
module adclim_bank (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire adclim_pkg::adclim_req_t req,
    input wire logic rd,
    output logic [15:0] rdata,
    input wire logic conv_start,
    input wire logic result_valid,
    input wire logic [23:0] result,
    output logic conv_accept,
    output logic powered_down,
    output adclim_pkg::adclim_ctl_t ctl,
    output logic [13:0] rate_tenths_hz,
    output logic alert
);
    // ----------------------------------------
    // register storage
    // ----------------------------------------
    logic [15:0] lower_alert_limit;
    logic [15:0] upper_alert_limit;
    logic [15:0] aux_settings;
    logic [15:0] main_settings;
    logic shutdown_seen;

    // ----------------------------------------
    // write decode
    // ----------------------------------------
    // strobes are qualified by wr, so the index alone never moves a register
    logic wr_lower;
    logic wr_upper;
    logic wr_aux;
    logic wr_main;

    assign wr_lower = req.wr && (req.index == `ADCLIM_IDX_LOWER);
    assign wr_upper = req.wr && (req.index == `ADCLIM_IDX_UPPER);
    assign wr_aux = req.wr && (req.index == `ADCLIM_IDX_AUX);
    assign wr_main = req.wr && (req.index == `ADCLIM_IDX_MAIN);

    // ----------------------------------------
    // limit registers
    // ----------------------------------------
    // whole-word writes only, so a comparison never sees half a limit
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            lower_alert_limit <= `ADCLIM_LOWER_RESET; // see RULE_02
        end else if (wr_lower) begin
            lower_alert_limit <= req.wdata; // see RULE_14
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            upper_alert_limit <= `ADCLIM_UPPER_RESET; // see RULE_02
        end else if (wr_upper) begin
            upper_alert_limit <= req.wdata; // see RULE_14
        end
    end

    // ----------------------------------------
    // auxiliary and main settings
    // ----------------------------------------
    // bit 8 lives for one cycle only; that cycle is the shutdown strobe
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            aux_settings <= `ADCLIM_AUX_RESET; // see RULE_10
        end else if (wr_aux) begin
            aux_settings <= req.wdata & `ADCLIM_AUX_MASK; // see RULE_13
        end else begin
            aux_settings[`ADCLIM_AUX_SHUTDOWN] <= 1'b0; // see RULE_03
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            main_settings <= `ADCLIM_MAIN_RESET; // see RULE_11
        end else if (wr_main) begin
            main_settings <= req.wdata;
        end
    end

    // ----------------------------------------
    // power state
    // ----------------------------------------
    // a start wins over a shutdown in the same cycle
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            shutdown_seen <= 1'b0;
        end else if (conv_start) begin
            shutdown_seen <= 1'b0; // see RULE_04
        end else if (aux_settings[`ADCLIM_AUX_SHUTDOWN]) begin
            shutdown_seen <= 1'b1; // see RULE_03
        end
    end
    assign powered_down = shutdown_seen;
    assign conv_accept = conv_start; // see RULE_04

    // ----------------------------------------
    // decoded controls
    // ----------------------------------------
    always_comb begin
        ctl.shutdown_pulse = aux_settings[`ADCLIM_AUX_SHUTDOWN];
        ctl.rate_code = main_settings[`ADCLIM_MAIN_RATE_HI:`ADCLIM_MAIN_RATE_LO];
        ctl.rate_table_select = aux_settings[`ADCLIM_AUX_TABLE];
        ctl.open_input_probe_current = aux_settings[`ADCLIM_AUX_PROBE]; // see RULE_07
        ctl.bus_leak_block = aux_settings[`ADCLIM_AUX_LEAK]; // see RULE_08
        ctl.outside_reference_select = aux_settings[`ADCLIM_AUX_EXTREF]; // see RULE_09
        ctl.window_style = main_settings[`ADCLIM_MAIN_STYLE];
    end

    // ----------------------------------------
    // conversion rate
    // ----------------------------------------
    // lookup keeps both rows exact up to 960 hz; 6.25 hz truncates to 62 tenths
    logic [13:0] next_rate_tenths_hz;

    always_comb begin
        next_rate_tenths_hz = `ADCLIM_RATE_A0;
        if (ctl.rate_table_select) begin
            case (ctl.rate_code)
                3'h0: next_rate_tenths_hz = `ADCLIM_RATE_B0; // see RULE_06
                3'h1: next_rate_tenths_hz = `ADCLIM_RATE_B1; // see RULE_06
                3'h2: next_rate_tenths_hz = `ADCLIM_RATE_B2; // see RULE_06
                3'h3: next_rate_tenths_hz = `ADCLIM_RATE_B3; // see RULE_06
                3'h4: next_rate_tenths_hz = `ADCLIM_RATE_B4; // see RULE_06
                3'h5: next_rate_tenths_hz = `ADCLIM_RATE_B5; // see RULE_06
                3'h6: next_rate_tenths_hz = `ADCLIM_RATE_B6; // see RULE_06
                3'h7: next_rate_tenths_hz = `ADCLIM_RATE_B7; // see RULE_06
                default: next_rate_tenths_hz = `ADCLIM_RATE_B0;
            endcase
        end else begin
            case (ctl.rate_code)
                3'h0: next_rate_tenths_hz = `ADCLIM_RATE_A0; // see RULE_05
                3'h1: next_rate_tenths_hz = `ADCLIM_RATE_A1; // see RULE_05
                3'h2: next_rate_tenths_hz = `ADCLIM_RATE_A2; // see RULE_05
                3'h3: next_rate_tenths_hz = `ADCLIM_RATE_A3; // see RULE_05
                3'h4: next_rate_tenths_hz = `ADCLIM_RATE_A4; // see RULE_05
                3'h5: next_rate_tenths_hz = `ADCLIM_RATE_A5; // see RULE_05
                3'h6: next_rate_tenths_hz = `ADCLIM_RATE_A6; // see RULE_05
                3'h7: next_rate_tenths_hz = `ADCLIM_RATE_A7; // see RULE_05
                default: next_rate_tenths_hz = `ADCLIM_RATE_A0;
            endcase
        end
    end

    // registered, so the rate lags a settings write by one cycle
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rate_tenths_hz <= `ADCLIM_RATE_A4; // matches the reset rate code 100
        end else begin
            rate_tenths_hz <= next_rate_tenths_hz;
        end
    end

    // ----------------------------------------
    // read path
    // ----------------------------------------
    // a cycle without a read strobe leaves the last answer standing
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata <= 16'h0000;
        end else if (rd) begin
            case (req.index)
                `ADCLIM_IDX_LOWER: rdata <= lower_alert_limit;
                `ADCLIM_IDX_UPPER: rdata <= upper_alert_limit;
                `ADCLIM_IDX_AUX: rdata <= aux_settings;
                `ADCLIM_IDX_MAIN: rdata <= main_settings;
                default: rdata <= 16'h0000;
            endcase
        end
    end

    // ----------------------------------------
    // comparator
    // ----------------------------------------
    logic signed [15:0] sample;
    logic above;
    logic below;
    logic at_or_below;
    logic next_alert;

    assign sample = result[23:8]; // see RULE_01
    assign above = sample > $signed(upper_alert_limit); // see RULE_01
    assign below = sample < $signed(lower_alert_limit); // see RULE_01
    assign at_or_below = sample <= $signed(lower_alert_limit);

    // hysteresis holds between the limits; window forgets the last sample
    always_comb begin
        next_alert = alert;
        if (ctl.window_style) begin
            next_alert = above || below; // see RULE_12
        end else if (above) begin
            next_alert = 1'b1; // see RULE_12
        end else if (at_or_below) begin
            next_alert = 1'b0; // see RULE_12
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            alert <= 1'b0;
        end else if (result_valid) begin
            alert <= next_alert;
        end
    end
endmodule

// >>> src/adclim_pkg.sv
// types for the adc limit and auxiliary settings bank
package adclim_pkg;
    typedef struct packed {
        logic [1:0] index;
        logic [15:0] wdata;
        logic wr;
    } adclim_req_t;
    typedef struct packed {
        logic shutdown_pulse;
        logic [2:0] rate_code;
        logic rate_table_select;
        logic open_input_probe_current;
        logic bus_leak_block;
        logic outside_reference_select;
        logic window_style;
    } adclim_ctl_t;
endpackage

// >>> src/adclim_regs.svh
// register map constants for the adc limit and auxiliary settings bank
`ifndef ADCLIM_REGS_SVH
`define ADCLIM_REGS_SVH
`define ADCLIM_IDX_LOWER 2'h0
`define ADCLIM_IDX_UPPER 2'h1
`define ADCLIM_IDX_AUX 2'h2
`define ADCLIM_IDX_MAIN 2'h3
`define ADCLIM_LOWER_RESET 16'h8000
`define ADCLIM_UPPER_RESET 16'h7fff
`define ADCLIM_AUX_RESET 16'h0000
`define ADCLIM_MAIN_RESET 16'h0080
`define ADCLIM_AUX_SHUTDOWN 8
`define ADCLIM_AUX_TABLE 7
`define ADCLIM_AUX_PROBE 6
`define ADCLIM_AUX_LEAK 4
`define ADCLIM_AUX_EXTREF 3
`define ADCLIM_AUX_MASK 16'h01d8
`define ADCLIM_MAIN_RATE_HI 7
`define ADCLIM_MAIN_RATE_LO 5
`define ADCLIM_MAIN_STYLE 4
`define ADCLIM_RATE_A0 14'h003e
`define ADCLIM_RATE_A1 14'h007d
`define ADCLIM_RATE_A2 14'h00fa
`define ADCLIM_RATE_A3 14'h01f4
`define ADCLIM_RATE_A4 14'h03e8
`define ADCLIM_RATE_A5 14'h07d0
`define ADCLIM_RATE_A6 14'h0fa0
`define ADCLIM_RATE_A7 14'h1f40
`define ADCLIM_RATE_B0 14'h004b
`define ADCLIM_RATE_B1 14'h0096
`define ADCLIM_RATE_B2 14'h012c
`define ADCLIM_RATE_B3 14'h0258
`define ADCLIM_RATE_B4 14'h04b0
`define ADCLIM_RATE_B5 14'h0960
`define ADCLIM_RATE_B6 14'h12c0
`define ADCLIM_RATE_B7 14'h2580
`endif
